// File: shared/dinfd_consts.vh
// Constants of the digital input function decoder.
// Assumes a plain register port with word indices, one clock, active-low reset.
`ifndef DINFD_CONSTS_VH
`define DINFD_CONSTS_VH

// ==========================================================
// Sizes
`define DINFD_NUM_IN 13
`define DINFD_NUM_PIN 10
`define DINFD_NUM_VIRT 3
`define DINFD_CODE_W 8
`define DINFD_ADDR_W 5

// ==========================================================
// Function codes
`define FN_SPEED_LIMIT 8'h10
`define FN_POS_B0 8'h11
`define FN_POS_B1 8'h12
`define FN_POS_B2 8'h13
`define FN_POS_B3 8'h1A
`define FN_POS_B4 8'h1B
`define FN_POS_B5 8'h1C
`define FN_POS_B6 8'h1E
`define FN_TURN_CLEAR 8'h1F
`define FN_ABS_ENABLE 8'h1D
`define FN_SPD_B0 8'h14
`define FN_SPD_B1 8'h15
`define FN_TRQ_B0 8'h16
`define FN_TRQ_B1 8'h17
`define FN_POS_SPEED 8'h18
`define FN_TRQ_SPEED 8'h19
`define FN_TRQ_POS 8'h20
`define FN_ESTOP 8'h21
`define FN_REV_LIMIT 8'h22
`define FN_PT_PR 8'h2B

// ==========================================================
// Register indices
`define REG_CODE_LAST 5'h0C
`define REG_POLARITY 5'h10
`define REG_VIRTUAL 5'h11
`define REG_OP_MODE 5'h12
`define REG_STOP_PROFILE 5'h13
`define REG_BRAKE_DELAY 5'h14
`define REG_STATUS 5'h15
`define REG_MASK 5'h16
`define REG_LEVELS 5'h17
`define REG_STATE 5'h18

// ==========================================================
// Operating modes (OP_MODE[2:0]); OP_MODE[3] picks register positioning except in multi mode
`define MODE_POS 3'h0
`define MODE_SPEED 3'h1
`define MODE_TORQUE 3'h2
`define MODE_DUAL_PS 3'h3
`define MODE_DUAL_ST 3'h4
`define MODE_DUAL_TP 3'h5
`define MODE_MULTI 3'h6
`define POS_SRC_BIT 3

// Active control loop
`define CTL_POS 2'h0
`define CTL_SPEED 2'h1
`define CTL_TORQUE 2'h2

// ==========================================================
// Status bits, also the mask layout
`define ST_TURN_CLEAR 0
`define ST_FAULT_E013 1
`define ST_A015_SET 2
`define ST_A015_CLEAR 3
`define ST_W 4

// Emergency stop states
`define ES_IDLE 2'h0
`define ES_DECEL 2'h1
`define ES_BRAKE 2'h2
`define ES_DONE 2'h3

`endif

// File: hw/dinfd_top.v
// Digital input function decoder: maps input function codes to drive control actions.
// Assumes pins already debounced and synchronous to clock; motion core reports standstill.
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ns
`include "dinfd_consts.vh"

// Function
// - Logical level is pin level, inverted when the input is set normally closed.
// - Speed limit input on in torque operation enables the speed cap.
// - Register positioning index bits 0..6 come from codes 11,12,13,1A,1B,1C,1E.
// - Rising edge of turn-count clear input clears encoder turn count in any mode.
// - Turn-count clear is ignored unless absolute enable input is on.
// - Codes 14 and 15 form preset speed select; speed limit select in torque.
// - Codes 16 and 17 form preset torque select; torque limit select otherwise.
// - Position/speed dual mode: off gives position, on gives speed.
// - Speed/torque dual mode: off gives speed, on gives torque.
// - Torque/position dual mode: off gives torque, on gives position.
// - Multi mode combines position/speed, torque/position and pulse/register selects.
// - Emergency stop on: decelerate by chosen profile, brake timing, then disable.
// - Finished emergency stop raises fault E013.
// - Reverse limit off raises alarm A015 and allows forward motion only.
// - Reverse limit back on clears the alarm by itself.
module dinfd_top (
  input wire clock,
  input wire rst_n,
  input wire [`DINFD_NUM_PIN-1:0] di_pin,
  input wire motion_stopped,
  input wire [`DINFD_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  output reg speed_limit_en,
  output reg [6:0] preset_pos_index,
  output reg [1:0] speed_sel,
  output reg [1:0] torque_sel,
  output reg turn_count_clear,
  output reg [1:0] active_control,
  output reg register_position_mode,
  output reg estop_decel,
  output reg [1:0] stop_profile_select,
  output reg brake_engage,
  output reg motor_disable,
  output reg fault_e013,
  output reg alarm_a015,
  output reg forward_only,
  output reg irq
);

  localparam NI = `DINFD_NUM_IN;
  localparam CW = `DINFD_CODE_W;

  // ==========================================================
  // Configuration and state registers
  reg [NI*CW-1:0] codes;
  reg [NI-1:0] polarity;
  reg [`DINFD_NUM_VIRT-1:0] virt_in;
  reg [3:0] op_mode;
  reg [15:0] brake_delay;
  reg [`ST_W-1:0] status;
  reg [`ST_W-1:0] mask;
  reg [NI-1:0] levels;
  reg turn_clear_prev;
  reg [1:0] es_state;
  reg [15:0] es_count;

  // True when any input carrying this code is logically on
  function fn_on;
    input [NI*CW-1:0] all_codes;
    input [NI-1:0] lv;
    input [CW-1:0] code;
    integer i;
    begin
      fn_on = 1'b0;
      for (i = 0; i < NI; i = i + 1) begin
        if (all_codes[i*CW +: CW] == code && lv[i])
          fn_on = 1'b1;
      end
    end
  endfunction

  // True when some input carries this code at all
  function fn_used;
    input [NI*CW-1:0] all_codes;
    input [CW-1:0] code;
    integer i;
    begin
      fn_used = 1'b0;
      for (i = 0; i < NI; i = i + 1) begin
        if (all_codes[i*CW +: CW] == code)
          fn_used = 1'b1;
      end
    end
  endfunction

  // ==========================================================
  // Input levels
  wire [NI-1:0] raw_in = {virt_in, di_pin};
  wire [NI-1:0] next_levels = raw_in ^ polarity;

  // Function signals; an input whose code matches none here is simply unread
  wire f_spd_lim = fn_on(codes, levels, `FN_SPEED_LIMIT);
  wire [6:0] f_pos = {fn_on(codes, levels, `FN_POS_B6), fn_on(codes, levels, `FN_POS_B5),
                      fn_on(codes, levels, `FN_POS_B4), fn_on(codes, levels, `FN_POS_B3),
                      fn_on(codes, levels, `FN_POS_B2), fn_on(codes, levels, `FN_POS_B1),
                      fn_on(codes, levels, `FN_POS_B0)};
  wire f_turn_clr = fn_on(codes, levels, `FN_TURN_CLEAR);
  wire f_abs_en = fn_on(codes, levels, `FN_ABS_ENABLE);
  wire [1:0] f_spd = {fn_on(codes, levels, `FN_SPD_B1), fn_on(codes, levels, `FN_SPD_B0)};
  wire [1:0] f_trq = {fn_on(codes, levels, `FN_TRQ_B1), fn_on(codes, levels, `FN_TRQ_B0)};
  wire f_ps = fn_on(codes, levels, `FN_POS_SPEED);
  wire f_ts = fn_on(codes, levels, `FN_TRQ_SPEED);
  wire f_tp = fn_on(codes, levels, `FN_TRQ_POS);
  wire f_ptpr = fn_on(codes, levels, `FN_PT_PR);
  wire f_estop = fn_on(codes, levels, `FN_ESTOP);
  // An unassigned reverse limit cannot raise the alarm
  wire rev_used = fn_used(codes, `FN_REV_LIMIT);
  wire f_rev_ok = fn_on(codes, levels, `FN_REV_LIMIT);

  // ==========================================================
  // Operating mode selection
  reg [1:0] next_control;
  reg next_reg_pos;
  always @* begin
    next_control = `CTL_POS;
    next_reg_pos = op_mode[`POS_SRC_BIT];
    case (op_mode[2:0])
      `MODE_SPEED: next_control = `CTL_SPEED;
      `MODE_TORQUE: next_control = `CTL_TORQUE;
      `MODE_DUAL_PS: next_control = f_ps ? `CTL_SPEED : `CTL_POS;
      `MODE_DUAL_ST: next_control = f_ts ? `CTL_TORQUE : `CTL_SPEED;
      `MODE_DUAL_TP: next_control = f_tp ? `CTL_POS : `CTL_TORQUE;
      `MODE_MULTI: begin
        // Speed select takes priority, then torque/position, pulse/register picks source
        if (f_ps)
          next_control = `CTL_SPEED;
        else if (f_tp)
          next_control = `CTL_POS;
        else
          next_control = `CTL_TORQUE;
        next_reg_pos = f_ptpr;
      end
      default: next_control = `CTL_POS;
    endcase
  end

  // Index is only meaningful while register positioning drives the position loop
  wire [6:0] next_pos_index = (next_control == `CTL_POS && next_reg_pos) ? f_pos : 7'h00;
  wire next_spd_lim = f_spd_lim && (next_control == `CTL_TORQUE);
  wire next_turn_clr = f_turn_clr && !turn_clear_prev && f_abs_en;
  wire next_alarm = rev_used && !f_rev_ok;

  // ==========================================================
  // Emergency stop sequence
  reg [1:0] next_es_state;
  reg [15:0] next_es_count;
  always @* begin
    next_es_state = es_state;
    next_es_count = es_count;
    case (es_state)
      `ES_IDLE: begin
        if (f_estop)
          next_es_state = `ES_DECEL;
      end
      `ES_DECEL: begin
        // Releasing during the ramp abandons the stop before any fault
        if (!f_estop)
          next_es_state = `ES_IDLE;
        else if (motion_stopped) begin
          next_es_state = `ES_BRAKE;
          next_es_count = 16'h0000;
        end
      end
      `ES_BRAKE: begin
        // Brake holds this long before torque is removed
        if (es_count >= brake_delay)
          next_es_state = `ES_DONE;
        else
          next_es_count = es_count + 16'h0001;
      end
      `ES_DONE: begin
        if (!f_estop)
          next_es_state = `ES_IDLE;
      end
      default: next_es_state = `ES_IDLE;
    endcase
  end
  wire es_enter_done = (es_state == `ES_BRAKE) && (next_es_state == `ES_DONE);

  // ==========================================================
  // Status events
  wire [`ST_W-1:0] events;
  assign events[`ST_TURN_CLEAR] = next_turn_clr;
  assign events[`ST_FAULT_E013] = es_enter_done;
  assign events[`ST_A015_SET] = next_alarm && !alarm_a015;
  assign events[`ST_A015_CLEAR] = !next_alarm && alarm_a015;
  wire [`ST_W-1:0] st_clear = (reg_wr && reg_addr == `REG_STATUS) ? reg_wdata[`ST_W-1:0] : {`ST_W{1'b0}};
  // A new event wins over a simultaneous write-one-to-clear
  wire [`ST_W-1:0] next_status = (status & ~st_clear) | events;

  // ==========================================================
  // Register writes and state
  integer k;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      codes <= {NI*CW{1'b0}};
      polarity <= {NI{1'b0}};
      virt_in <= {`DINFD_NUM_VIRT{1'b0}};
      op_mode <= 4'h0;
      stop_profile_select <= 2'h0;
      brake_delay <= 16'h0000;
      status <= {`ST_W{1'b0}};
      mask <= {`ST_W{1'b0}};
      levels <= {NI{1'b0}};
      turn_clear_prev <= 1'b0;
      es_state <= `ES_IDLE;
      es_count <= 16'h0000;
    end else begin
      levels <= next_levels;
      turn_clear_prev <= f_turn_clr;
      es_state <= next_es_state;
      es_count <= next_es_count;
      status <= next_status;
      if (reg_wr) begin
        if (reg_addr <= `REG_CODE_LAST) begin
          for (k = 0; k < NI; k = k + 1) begin
            if (reg_addr == k[`DINFD_ADDR_W-1:0])
              codes[k*CW +: CW] <= reg_wdata[CW-1:0];
          end
        end else if (reg_addr == `REG_POLARITY) begin
          polarity <= reg_wdata[NI-1:0];
        end else if (reg_addr == `REG_VIRTUAL) begin
          virt_in <= reg_wdata[`DINFD_NUM_VIRT-1:0];
        end else if (reg_addr == `REG_OP_MODE) begin
          op_mode <= reg_wdata[3:0];
        end else if (reg_addr == `REG_STOP_PROFILE) begin
          stop_profile_select <= reg_wdata[1:0];
        end else if (reg_addr == `REG_BRAKE_DELAY) begin
          brake_delay <= reg_wdata[15:0];
        end else if (reg_addr == `REG_MASK) begin
          mask <= reg_wdata[`ST_W-1:0];
        end
      end
    end
  end

  // ==========================================================
  // Read port, data one cycle after the strobe
  reg [31:0] next_rdata;
  // Own loop index, so the clocked and combinational processes share no variable
  integer m;
  always @* begin
    next_rdata = 32'h0000_0000;
    if (reg_addr <= `REG_CODE_LAST) begin
      for (m = 0; m < NI; m = m + 1) begin
        if (reg_addr == m[`DINFD_ADDR_W-1:0])
          next_rdata[CW-1:0] = codes[m*CW +: CW];
      end
    end else if (reg_addr == `REG_POLARITY) begin
      next_rdata[NI-1:0] = polarity;
    end else if (reg_addr == `REG_VIRTUAL) begin
      next_rdata[`DINFD_NUM_VIRT-1:0] = virt_in;
    end else if (reg_addr == `REG_OP_MODE) begin
      next_rdata[3:0] = op_mode;
    end else if (reg_addr == `REG_STOP_PROFILE) begin
      next_rdata[1:0] = stop_profile_select;
    end else if (reg_addr == `REG_BRAKE_DELAY) begin
      next_rdata[15:0] = brake_delay;
    end else if (reg_addr == `REG_STATUS) begin
      next_rdata[`ST_W-1:0] = status;
    end else if (reg_addr == `REG_MASK) begin
      next_rdata[`ST_W-1:0] = mask;
    end else if (reg_addr == `REG_LEVELS) begin
      next_rdata[NI-1:0] = levels;
    end else if (reg_addr == `REG_STATE) begin
      next_rdata[5:0] = {alarm_a015, fault_e013, active_control, es_state};
    end
  end

  // ==========================================================
  // Registered outputs
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
      speed_limit_en <= 1'b0;
      preset_pos_index <= 7'h00;
      speed_sel <= 2'h0;
      torque_sel <= 2'h0;
      turn_count_clear <= 1'b0;
      active_control <= `CTL_POS;
      register_position_mode <= 1'b0;
      estop_decel <= 1'b0;
      brake_engage <= 1'b0;
      motor_disable <= 1'b0;
      fault_e013 <= 1'b0;
      alarm_a015 <= 1'b0;
      forward_only <= 1'b0;
      irq <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : 32'h0000_0000;
      speed_limit_en <= next_spd_lim;
      preset_pos_index <= next_pos_index;
      speed_sel <= f_spd;
      torque_sel <= f_trq;
      turn_count_clear <= next_turn_clr;
      active_control <= next_control;
      register_position_mode <= next_reg_pos;
      estop_decel <= (next_es_state == `ES_DECEL);
      brake_engage <= (next_es_state == `ES_BRAKE) || (next_es_state == `ES_DONE);
      motor_disable <= (next_es_state == `ES_DONE);
      fault_e013 <= (next_es_state == `ES_DONE);
      alarm_a015 <= next_alarm;
      forward_only <= next_alarm;
      irq <= |(next_status & mask);
    end
  end

endmodule

// File: test/dinfd_top_chk.sv
// Concurrent checks on the outputs of the input function decoder.
// Assumes it is bound to dinfd_top; one clock, asynchronous active-low reset.
`timescale 1ns/1ns
`include "dinfd_consts.vh"
module dinfd_top_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic motion_stopped,
  input wire logic speed_limit_en,
  input wire logic [6:0] preset_pos_index,
  input wire logic turn_count_clear,
  input wire logic [1:0] active_control,
  input wire logic register_position_mode,
  input wire logic estop_decel,
  input wire logic brake_engage,
  input wire logic motor_disable,
  input wire logic fault_e013,
  input wire logic alarm_a015,
  input wire logic forward_only
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Stop sequence steps
  sequence s_stop_reached;
    estop_decel && motion_stopped;
  endsequence
  sequence s_braking;
    brake_engage && !estop_decel;
  endsequence
  // ==========================================================
  // Assertions
  chk_rdata_idle: assert property ((reg_rdata != 32'h0000_0000) |-> $past(reg_rd))
    else $error("read data outside read slot");
  chk_decel_brake: assert property (s_stop_reached |=> s_braking)
    else $error("no brake after standstill");
  chk_disable_braked: assert property (motor_disable |-> brake_engage)
    else $error("motor disabled without brake");
  chk_brake_first: assert property ($rose(motor_disable) |-> $past(brake_engage))
    else $error("disable without brake phase");
  chk_fault_disable: assert property (fault_e013 == motor_disable)
    else $error("fault and disable differ");
  chk_clear_pulse: assert property (turn_count_clear |=> !turn_count_clear)
    else $error("turn clear longer than one cycle");
  chk_fwd_alarm: assert property (forward_only == alarm_a015)
    else $error("forward only differs from alarm");
  chk_limit_torque: assert property (speed_limit_en |-> active_control == `CTL_TORQUE)
    else $error("speed cap outside torque control");
  chk_index_source: assert property ((preset_pos_index != 7'h00) |->
    (active_control == `CTL_POS) && register_position_mode)
    else $error("position index outside register positioning");
endmodule
bind dinfd_top dinfd_top_chk i_chk (.clock(clock), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .motion_stopped(motion_stopped), .speed_limit_en(speed_limit_en), .preset_pos_index(preset_pos_index),
  .turn_count_clear(turn_count_clear), .active_control(active_control),
  .register_position_mode(register_position_mode), .estop_decel(estop_decel), .brake_engage(brake_engage),
  .motor_disable(motor_disable), .fault_e013(fault_e013), .alarm_a015(alarm_a015), .forward_only(forward_only));

// File: test/dinfd_field_model.sv
// Field side: switches on the input pins and a motion core that reports standstill.
// Assumes switch levels come from the bench; standstill follows a stop after stop_delay cycles.
`timescale 1ns/1ns
module dinfd_field_model (
  input wire logic clock,
  input wire logic [9:0] sw,
  input wire logic run,
  input wire logic [7:0] stop_delay,
  output logic [9:0] di_pin,
  output logic motion_stopped
);
  logic [7:0] cnt;
  // Pins change only at edges, as the decoder assumes synchronous inputs
  always @(posedge clock) begin
    di_pin <= sw;
    cnt <= run ? cnt + 8'(cnt != stop_delay) : 8'h00;
    motion_stopped <= run && (cnt == stop_delay);
  end
endmodule

// File: test/tb_top.sv
// Testbench of the input function decoder.
// Assumes dinfd_top, its checker and the field model are compiled before it.
`timescale 1ns/1ns
`include "dinfd_consts.vh"
module tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [9:0] sw = 10'h000;
  logic [7:0] stop_delay = 8'h14;
  wire [9:0] di_pin;
  wire [31:0] reg_rdata;
  wire [6:0] preset_pos_index;
  wire [1:0] speed_sel, torque_sel, active_control, stop_profile_select;
  wire motion_stopped, speed_limit_en, turn_count_clear, register_position_mode, estop_decel;
  wire brake_engage, motor_disable, fault_e013, alarm_a015, forward_only, irq;
  integer n_errors = 0;
  integer samples_checked = 0;
  integer cycles = 0;
  integer pulses = 0;
  integer p0 = 0;
  integer i, j;
  logic [9:0] pats [0:4] = '{10'h3FF, 10'h2AA, 10'h155, 10'h001, 10'h040};
  logic [11:0] rows [0:9] = '{{`MODE_DUAL_PS, 5'h00, `CTL_POS, 2'h0}, {`MODE_DUAL_PS, 5'h01, `CTL_SPEED, 2'h0},
    {`MODE_DUAL_ST, 5'h08, `CTL_SPEED, 2'h0}, {`MODE_DUAL_ST, 5'h0A, `CTL_TORQUE, 2'h2},
    {`MODE_DUAL_TP, 5'h00, `CTL_TORQUE, 2'h0}, {`MODE_DUAL_TP, 5'h04, `CTL_POS, 2'h0},
    {`MODE_MULTI, 5'h01, `CTL_SPEED, 2'h0}, {`MODE_MULTI, 5'h14, `CTL_POS, 2'h1},
    {`MODE_MULTI, 5'h08, `CTL_TORQUE, 2'h2}, {`MODE_MULTI, 5'h05, `CTL_SPEED, 2'h0}};
  dinfd_top i_dinfd_top (.clock(clock), .rst_n(rst_n), .di_pin(di_pin), .motion_stopped(motion_stopped),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .speed_limit_en(speed_limit_en), .preset_pos_index(preset_pos_index), .speed_sel(speed_sel),
    .torque_sel(torque_sel), .turn_count_clear(turn_count_clear), .active_control(active_control),
    .register_position_mode(register_position_mode), .estop_decel(estop_decel),
    .stop_profile_select(stop_profile_select), .brake_engage(brake_engage), .motor_disable(motor_disable),
    .fault_e013(fault_e013), .alarm_a015(alarm_a015), .forward_only(forward_only), .irq(irq));
  dinfd_field_model i_dinfd_field_model (.clock(clock), .sw(sw), .run(estop_decel | brake_engage),
    .stop_delay(stop_delay), .di_pin(di_pin), .motion_stopped(motion_stopped));
  always #20 clock = ~clock;
  // ==========================================================
  // Watchdog and pulse counter
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (turn_count_clear === 1'b1) pulses = pulses + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      end_sim;
    end
  end
  // ==========================================================
  // Shared tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [4:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // Pin change needs model, levels and output registers to settle
  task pins(input logic [9:0] v);
    @(posedge clock);
    sw <= v;
    repeat (4) @(posedge clock);
    #1;
  endtask
  task clr;
    for (j = 0; j < 13; j = j + 1) wr(j[4:0], 32'h0000_0000);
    wr(`REG_OP_MODE, 32'h0000_0000);
    wr(`REG_VIRTUAL, 32'h0000_0000);
    pins(10'h000);
  endtask
  // ==========================================================
  // Scenarios
  task t_regs;
    rd(`REG_STATUS, 32'h0000_0000);
    wr(5'h00, 32'h0000_001F);
    rd(5'h00, 32'h0000_001F);
    wr(5'h1F, 32'hFFFF_FFFF);
    rd(5'h1F, 32'h0000_0000);
    wr(`REG_LEVELS, 32'h0000_1FFF);
    rd(`REG_LEVELS, 32'h0000_0000);
    wr(`REG_STOP_PROFILE, 32'h0000_0002);
    #1 chk(32'(stop_profile_select), 32'h0000_0002);
  endtask
  task t_polarity;
    clr;
    wr(`REG_POLARITY, 32'h0000_1008);
    pins(10'h009);
    rd(`REG_LEVELS, 32'h0000_1001);
    wr(`REG_VIRTUAL, 32'h0000_0004);
    rd(`REG_LEVELS, 32'h0000_0001);
    wr(`REG_POLARITY, 32'h0000_0000);
  endtask
  task t_select;
    clr;
    wr(`REG_OP_MODE, 32'h0000_0008);
    for (i = 0; i < 10; i = i + 1) wr(i[4:0], 32'(({24'h00_0000, 8'h11, 8'h12, 8'h13, 8'h1A, 8'h1B, 8'h1C,
      8'h1E, 8'h14, 8'h15, 8'h16} >> (8 * (9 - i))) & 32'h0000_00FF));
    wr(5'h0A, 32'h0000_0017);
    for (i = 0; i < 5; i = i + 1) begin
      pins(pats[i]);
      chk(32'(preset_pos_index), 32'(pats[i][6:0]));
      chk(32'(speed_sel), 32'(pats[i][8:7]));
      chk(32'(torque_sel), 32'(pats[i][9]));
    end
    wr(`REG_VIRTUAL, 32'h0000_0001);
    pins(10'h3FF);
    chk(32'(torque_sel), 32'h0000_0003);
    wr(5'h00, 32'h0000_000E);
    pins(10'h3FF);
    chk(32'(preset_pos_index), 32'h0000_007E);
    wr(`REG_OP_MODE, 32'(`MODE_SPEED));
    pins(10'h3FF);
    chk(32'(preset_pos_index), 32'h0000_0000);
  endtask
  task t_modes;
    clr;
    wr(5'h00, 32'h0000_0018);
    wr(5'h01, 32'h0000_0019);
    wr(5'h02, 32'h0000_0020);
    wr(5'h03, 32'h0000_0010);
    wr(5'h04, 32'h0000_002B);
    for (i = 0; i < 10; i = i + 1) begin
      wr(`REG_OP_MODE, 32'(rows[i][11:9]));
      pins({5'h00, rows[i][8:4]});
      chk(32'(active_control), 32'(rows[i][3:2]));
      chk(32'(speed_limit_en), 32'(rows[i][1]));
      chk(32'(register_position_mode), 32'(rows[i][0]));
    end
  endtask
  task t_clear;
    clr;
    wr(5'h00, 32'h0000_001F);
    wr(5'h01, 32'h0000_001D);
    p0 = pulses;
    pins(10'h001);
    pins(10'h000);
    chk(pulses - p0, 0);
    pins(10'h002);
    pins(10'h003);
    pins(10'h003);
    chk(pulses - p0, 1);
    pins(10'h002);
    wr(`REG_OP_MODE, 32'(`MODE_TORQUE));
    pins(10'h003);
    chk(pulses - p0, 2);
    wr(`REG_STATUS, 32'h0000_000F);
  endtask
  task t_estop;
    clr;
    wr(5'h00, 32'h0000_0021);
    wr(`REG_BRAKE_DELAY, 32'h0000_0003);
    wr(`REG_MASK, 32'h0000_0002);
    pins(10'h001);
    chk(32'(estop_decel), 32'h0000_0001);
    pins(10'h000);
    chk(32'({estop_decel, fault_e013}), 32'h0000_0000);
    pins(10'h001);
    for (i = 0; i < 80 && motor_disable !== 1'b1; i = i + 1) @(posedge clock);
    #1 chk(32'({brake_engage, motor_disable, fault_e013, irq}), 32'h0000_000F);
    rd(`REG_STATUS, 32'h0000_0002);
    wr(`REG_MASK, 32'h0000_0000);
    repeat (2) @(posedge clock);
    #1 chk(32'(irq), 32'h0000_0000);
    wr(`REG_MASK, 32'h0000_0002);
    pins(10'h000);
    chk(32'({motor_disable, fault_e013}), 32'h0000_0000);
    wr(`REG_STATUS, 32'h0000_0002);
    repeat (2) @(posedge clock);
    #1 chk(32'(irq), 32'h0000_0000);
  endtask
  task t_revlimit;
    clr;
    pins(10'h001);
    wr(5'h00, 32'h0000_0022);
    pins(10'h001);
    chk(32'(alarm_a015), 32'h0000_0000);
    pins(10'h000);
    chk(32'({alarm_a015, forward_only}), 32'h0000_0003);
    pins(10'h001);
    chk(32'(alarm_a015), 32'h0000_0000);
    rd(`REG_STATUS, 32'h0000_000C);
  endtask
  task end_sim;
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_regs;
    t_polarity;
    t_select;
    t_modes;
    t_clear;
    t_estop;
    t_revlimit;
    end_sim;
  end
endmodule
